// ---- hw/bfad_cfg.svh ----
`ifndef BFAD_CFG_SVH
`define BFAD_CFG_SVH

// ----------------------------------------
// Register offsets and reset values
// ----------------------------------------
`define BFAD_OFS_PERF_CTR3 8'h20
`define BFAD_OFS_PERF_SEL3 8'h24
`define BFAD_OFS_IRQ_STAT 8'h28
`define BFAD_OFS_IRQ_MASK 8'h2C
`define BFAD_RST_PERF_SEL3 5'h1F
`define BFAD_RST_IRQ_MASK 3'h0
`define BFAD_PERF_SEL_LSB 0
`define BFAD_PERF_SEL_W 5
`define BFAD_PERF_CTR_W 24
`define BFAD_PERF_CODES 5'h14
`define BFAD_IRQ_BITS 3
`define BFAD_IRQ_LINES 26

// ----------------------------------------
// Address map, end addresses exclusive
// ----------------------------------------
`define BFAD_ROM_BASE 32'h0000_0000
`define BFAD_ROM_END 32'h0000_4000
`define BFAD_XIP_BASE 32'h1000_0000
`define BFAD_XIP_NOALLOC_BASE 32'h1100_0000
`define BFAD_XIP_NOCACHE_BASE 32'h1200_0000
`define BFAD_XIP_NCNA_BASE 32'h1300_0000
`define BFAD_XIP_CTRL_BASE 32'h1400_0000
`define BFAD_XIP_SRAM_BASE 32'h1500_0000
`define BFAD_XIP_SRAM_END 32'h1500_4000
`define BFAD_XIP_SSI_BASE 32'h1800_0000
`define BFAD_XIP_WIN 32'h0100_0000
`define BFAD_SRAM_STRIPED_BASE 32'h2000_0000
`define BFAD_SRAM_STRIPED_END 32'h2004_0000
`define BFAD_SRAM4_BASE 32'h2004_0000
`define BFAD_SRAM5_BASE 32'h2004_1000
`define BFAD_SRAM_END 32'h2004_2000
`define BFAD_SRAM0_ALIAS_BASE 32'h2100_0000
`define BFAD_SRAM_ALIAS_STEP 32'h0001_0000
`define BFAD_APB_BASE 32'h4000_0000
`define BFAD_APB_END 32'h4007_0000
`define BFAD_APB_SLOT_LSB 14
`define BFAD_DMA_BASE 32'h5000_0000
`define BFAD_USB_BUF_BASE 32'h5010_0000
`define BFAD_USB_REGS_BASE 32'h5011_0000
`define BFAD_USB_REGS_END 32'h5012_0000
`define BFAD_PIO_FIRST_BASE 32'h5020_0000
`define BFAD_PIO_SECOND_BASE 32'h5030_0000
`define BFAD_XIP_AUX_BASE 32'h5040_0000
`define BFAD_AHB_WIN 32'h0010_0000
`define BFAD_AUX_PORT_BASE 32'hD000_0000
`define BFAD_PPB_BASE 32'hE000_0000
`define BFAD_SEG_WIN 32'h1000_0000

`endif

// ---- hw/bfad_pkg.sv ----
package bfad_pkg;

    // Downstream target of one access
    typedef enum logic [4:0] {
        TGT_NONE,
        TGT_ROM,
        TGT_XIP_CACHE,
        TGT_XIP_NOALLOC,
        TGT_XIP_NOCACHE,
        TGT_XIP_NCNA,
        TGT_XIP_CTRL,
        TGT_XIP_SRAM,
        TGT_XIP_SSI,
        TGT_SRAM_STRIPED,
        TGT_SRAM4,
        TGT_SRAM5,
        TGT_SRAM_ALIAS,
        TGT_APB,
        TGT_DMA,
        TGT_USB_BUF,
        TGT_USB_REGS,
        TGT_PIO_FIRST,
        TGT_PIO_SECOND,
        TGT_XIP_AUX,
        TGT_AUX_PORT,
        TGT_PPB
    } bfad_target_t;

    typedef struct packed {
        bfad_target_t target;
        logic [4:0] slot;
    } bfad_route_t;

endpackage

// ---- hw/bfad_irq_if.sv ----
`timescale 1ns/1ns
`default_nettype none

interface bfad_irq_if;
    logic [2:0] evt;
    logic wr_stat;
    logic wr_mask;
    logic [2:0] wdata;
    logic [2:0] stat;
    logic [2:0] mask;
    logic irq;

    modport ctrl (input evt, wr_stat, wr_mask, wdata, output stat, mask, irq);
    modport host (output evt, wr_stat, wr_mask, wdata, input stat, mask, irq);
endinterface

`default_nettype wire

// ---- hw/bfad_irq_ctrl.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "bfad_cfg.svh"

module bfad_irq_ctrl (
    input wire logic clk_in, // System clock
    input wire logic rst_n_in, // Synchronous reset, active low
    bfad_irq_if.ctrl bus // Events, register writes, status
);
    logic [2:0] stat_ff;
    logic [2:0] mask_ff;
    logic [2:0] nxt_stat;

    // ----------------------------------------
    // Sticky status, write one to clear
    // ----------------------------------------
    always_comb begin
        nxt_stat = stat_ff;
        if (bus.wr_stat) begin
            nxt_stat = nxt_stat & ~bus.wdata;
        end
        // A new event beats a clear in the same cycle
        nxt_stat = nxt_stat | bus.evt;
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            stat_ff <= 3'h0;
        end else begin
            stat_ff <= nxt_stat;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            mask_ff <= `BFAD_RST_IRQ_MASK;
        end else if (bus.wr_mask) begin
            mask_ff <= bus.wdata;
        end
    end

    assign bus.stat = stat_ff;
    assign bus.mask = mask_ff;
    assign bus.irq = |(stat_ff & mask_ff);
endmodule

`default_nettype wire

// ---- hw/bfad_perf_counter.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "bfad_cfg.svh"

module bfad_perf_counter (
    input wire logic clk_in, // System clock
    input wire logic rst_n_in, // Synchronous reset, active low
    input wire logic [4:0] sel_in, // Event select code
    input wire logic [9:0] access_in, // Access per downstream port
    input wire logic [9:0] contested_in, // Contested access per port
    input wire logic clear_in, // Clear pulse
    output logic [23:0] count_out, // Saturating count
    output logic sat_out // Pulse when count reaches maximum
);
    logic [23:0] count_ff;
    logic event_hit;
    logic at_max;

    // Codes pair per port: even contested, odd all accesses
    always_comb begin
        event_hit = 1'b0;
        if (sel_in < `BFAD_PERF_CODES) begin
            event_hit = sel_in[0] ? access_in[sel_in[4:1]] : contested_in[sel_in[4:1]];
        end
    end

    assign at_max = &count_ff;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            count_ff <= 24'h000000;
        end else if (clear_in) begin
            count_ff <= 24'h000000;
        end else if (event_hit && !at_max) begin
            count_ff <= count_ff + 24'h000001;
        end
    end

    assign count_out = count_ff;
    assign sat_out = event_hit && !clear_in && (count_ff == 24'hFFFFFE);
endmodule

`default_nettype wire

// ---- hw/bfad_top.sv ----
// Behaviour
// - Unmapped address access returns a bus error to the requesting master.
// - Five-bit event select, read-write, bits 4:0, reset 0x1F, upper bits zero.
// - Codes pair per port: even contested, odd all; APB first, ROM last.
// - Striped SRAM banks 0-3 occupy 0x20000000 up to 0x20040000.
// - Bank 4 at 0x20040000, bank 5 at 0x20041000, SRAM ends 0x20042000.
// - Non-striped aliases of banks 0-3 from 0x21000000, step 0x10000.
// - Flash window aliases, control, cache-as-SRAM and serial interface bases.
// - USB buffer memory at 0x50100000, USB control registers at 0x50110000.
// - DMA, two programmable IO blocks and flash auxiliary port bases.
// - APB peripherals in 16 KiB slots from 0x40000000.
// - Each processor has its own port and is decoded independently.
// - Core-local IO segment 0xD0000000 goes to the auxiliary port.
// - All 26 interrupt lines and the NMI reach both processors.
// - 24-bit saturating counter of selected event, any write to its offset clears it.
`timescale 1ns/1ns
`default_nettype none
`include "bfad_cfg.svh"

module bfad_top (
    input wire logic REF_CLK_IN, // 100 MHz system clock
    input wire logic RESET_N_IN, // Synchronous reset, active low
    input wire logic [31:0] M0_ADDR_IN, // Core 0 access address
    input wire logic M0_VALID_IN, // Core 0 access request
    input wire logic [31:0] M1_ADDR_IN, // Core 1 access address
    input wire logic M1_VALID_IN, // Core 1 access request
    output logic [4:0] M0_TARGET_OUT, // Core 0 decoded target
    output logic [4:0] M0_SLOT_OUT, // Core 0 APB slot or SRAM alias
    output logic M0_SEL_OUT, // Core 0 decode valid
    output logic M0_ERROR_OUT, // Core 0 bus error
    output logic [4:0] M1_TARGET_OUT, // Core 1 decoded target
    output logic [4:0] M1_SLOT_OUT, // Core 1 APB slot or SRAM alias
    output logic M1_SEL_OUT, // Core 1 decode valid
    output logic M1_ERROR_OUT, // Core 1 bus error
    input wire logic [9:0] PERF_ACCESS_IN, // Access per downstream port
    input wire logic [9:0] PERF_CONTESTED_IN, // Contested access per port
    input wire logic [25:0] IRQ_LINES_IN, // System interrupt lines
    input wire logic NMI_IN, // Non-maskable interrupt
    output logic [25:0] CORE0_IRQ_OUT, // Interrupts to core 0
    output logic [25:0] CORE1_IRQ_OUT, // Interrupts to core 1
    output logic CORE0_NMI_OUT, // NMI to core 0
    output logic CORE1_NMI_OUT, // NMI to core 1
    input wire logic [7:0] REG_ADDR_IN, // Register byte address
    input wire logic [31:0] REG_WDATA_IN, // Register write data
    input wire logic REG_WR_IN, // Register write strobe
    input wire logic REG_RD_IN, // Register read strobe
    output logic [31:0] REG_RDATA_OUT, // Read data, cycle after strobe
    output logic IRQ_OUT // Fabric interrupt, level
);

    // ----------------------------------------
    // Address decode helpers
    // ----------------------------------------
    function automatic logic in_rng(
        input logic [31:0] a,
        input logic [31:0] lo,
        input logic [31:0] hi
    );
        in_rng = (a >= lo) && (a < hi);
    endfunction

    function automatic bfad_pkg::bfad_route_t decode_addr(input logic [31:0] a);
        bfad_pkg::bfad_route_t r;
        r.target = bfad_pkg::TGT_NONE;
        r.slot = 5'h00;
        // Priority chain keeps a single target even if ranges were to overlap
        if (in_rng(a, `BFAD_ROM_BASE, `BFAD_ROM_END)) begin
            r.target = bfad_pkg::TGT_ROM;
        end else if (in_rng(a, `BFAD_XIP_BASE, `BFAD_XIP_NOALLOC_BASE)) begin
            r.target = bfad_pkg::TGT_XIP_CACHE;
        end else if (in_rng(a, `BFAD_XIP_NOALLOC_BASE, `BFAD_XIP_NOCACHE_BASE)) begin
            r.target = bfad_pkg::TGT_XIP_NOALLOC;
        end else if (in_rng(a, `BFAD_XIP_NOCACHE_BASE, `BFAD_XIP_NCNA_BASE)) begin
            r.target = bfad_pkg::TGT_XIP_NOCACHE;
        end else if (in_rng(a, `BFAD_XIP_NCNA_BASE, `BFAD_XIP_CTRL_BASE)) begin
            r.target = bfad_pkg::TGT_XIP_NCNA;
        end else if (in_rng(a, `BFAD_XIP_CTRL_BASE, `BFAD_XIP_SRAM_BASE)) begin
            r.target = bfad_pkg::TGT_XIP_CTRL;
        end else if (in_rng(a, `BFAD_XIP_SRAM_BASE, `BFAD_XIP_SRAM_END)) begin
            r.target = bfad_pkg::TGT_XIP_SRAM;
        end else if (in_rng(a, `BFAD_XIP_SSI_BASE, `BFAD_XIP_SSI_BASE + `BFAD_XIP_WIN)) begin
            r.target = bfad_pkg::TGT_XIP_SSI;
        end else if (in_rng(a, `BFAD_SRAM_STRIPED_BASE, `BFAD_SRAM_STRIPED_END)) begin
            r.target = bfad_pkg::TGT_SRAM_STRIPED;
        end else if (in_rng(a, `BFAD_SRAM4_BASE, `BFAD_SRAM5_BASE)) begin
            r.target = bfad_pkg::TGT_SRAM4;
        end else if (in_rng(a, `BFAD_SRAM5_BASE, `BFAD_SRAM_END)) begin
            r.target = bfad_pkg::TGT_SRAM5;
        end else if (in_rng(a, `BFAD_SRAM0_ALIAS_BASE,
                            `BFAD_SRAM0_ALIAS_BASE + 4 * `BFAD_SRAM_ALIAS_STEP)) begin
            r.target = bfad_pkg::TGT_SRAM_ALIAS;
            r.slot = {3'h0, a[17:16]};
        end else if (in_rng(a, `BFAD_APB_BASE, `BFAD_APB_END)) begin
            r.target = bfad_pkg::TGT_APB;
            r.slot = a[`BFAD_APB_SLOT_LSB +: 5];
        end else if (in_rng(a, `BFAD_DMA_BASE, `BFAD_DMA_BASE + `BFAD_AHB_WIN)) begin
            r.target = bfad_pkg::TGT_DMA;
        end else if (in_rng(a, `BFAD_USB_BUF_BASE, `BFAD_USB_REGS_BASE)) begin
            r.target = bfad_pkg::TGT_USB_BUF;
        end else if (in_rng(a, `BFAD_USB_REGS_BASE, `BFAD_USB_REGS_END)) begin
            r.target = bfad_pkg::TGT_USB_REGS;
        end else if (in_rng(a, `BFAD_PIO_FIRST_BASE, `BFAD_PIO_SECOND_BASE)) begin
            r.target = bfad_pkg::TGT_PIO_FIRST;
        end else if (in_rng(a, `BFAD_PIO_SECOND_BASE, `BFAD_XIP_AUX_BASE)) begin
            r.target = bfad_pkg::TGT_PIO_SECOND;
        end else if (in_rng(a, `BFAD_XIP_AUX_BASE, `BFAD_XIP_AUX_BASE + `BFAD_AHB_WIN)) begin
            r.target = bfad_pkg::TGT_XIP_AUX;
        end else if (a[31:28] == 4'(`BFAD_AUX_PORT_BASE >> 28)) begin
            r.target = bfad_pkg::TGT_AUX_PORT;
        end else if (a[31:28] == 4'(`BFAD_PPB_BASE >> 28)) begin
            r.target = bfad_pkg::TGT_PPB;
        end
        decode_addr = r;
    endfunction

    // ----------------------------------------
    // Per-core decode, registered into data phase
    // ----------------------------------------
    logic [1:0][31:0] m_addr;
    logic [1:0] m_valid;
    bfad_pkg::bfad_route_t route_ff [2];
    logic [1:0] sel_ff;
    logic [1:0] err_ff;

    assign m_addr[0] = M0_ADDR_IN;
    assign m_addr[1] = M1_ADDR_IN;
    assign m_valid[0] = M0_VALID_IN;
    assign m_valid[1] = M1_VALID_IN;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_core
            bfad_pkg::bfad_route_t nxt_route;

            assign nxt_route = decode_addr(m_addr[gi]);

            always_ff @(posedge REF_CLK_IN) begin
                if (!RESET_N_IN) begin
                    route_ff[gi] <= '{bfad_pkg::TGT_NONE, 5'h00};
                    sel_ff[gi] <= 1'b0;
                    err_ff[gi] <= 1'b0;
                end else begin
                    route_ff[gi] <= m_valid[gi] ? nxt_route : '{bfad_pkg::TGT_NONE, 5'h00};
                    sel_ff[gi] <= m_valid[gi] && (nxt_route.target != bfad_pkg::TGT_NONE);
                    err_ff[gi] <= m_valid[gi] && (nxt_route.target == bfad_pkg::TGT_NONE);
                end
            end
        end
    endgenerate

    assign M0_TARGET_OUT = route_ff[0].target;
    assign M0_SLOT_OUT = route_ff[0].slot;
    assign M0_SEL_OUT = sel_ff[0];
    assign M0_ERROR_OUT = err_ff[0];
    assign M1_TARGET_OUT = route_ff[1].target;
    assign M1_SLOT_OUT = route_ff[1].slot;
    assign M1_SEL_OUT = sel_ff[1];
    assign M1_ERROR_OUT = err_ff[1];

    // ----------------------------------------
    // Interrupt fan-out to both cores
    // ----------------------------------------
    logic [25:0] irq_lines_ff;
    logic nmi_ff;

    always_ff @(posedge REF_CLK_IN) begin
        if (!RESET_N_IN) begin
            irq_lines_ff <= 26'h0000000;
            nmi_ff <= 1'b0;
        end else begin
            irq_lines_ff <= IRQ_LINES_IN;
            nmi_ff <= NMI_IN;
        end
    end

    assign CORE0_IRQ_OUT = irq_lines_ff;
    assign CORE1_IRQ_OUT = irq_lines_ff;
    assign CORE0_NMI_OUT = nmi_ff;
    assign CORE1_NMI_OUT = nmi_ff;

    // ----------------------------------------
    // Register file
    // ----------------------------------------
    logic [4:0] perf_event_select_three_ff;
    logic [23:0] perf_counter_three;
    logic perf_sat;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic hit_ctr;
    logic hit_sel;
    logic hit_stat;
    logic hit_mask;

    assign hit_ctr = REG_ADDR_IN == `BFAD_OFS_PERF_CTR3;
    assign hit_sel = REG_ADDR_IN == `BFAD_OFS_PERF_SEL3;
    assign hit_stat = REG_ADDR_IN == `BFAD_OFS_IRQ_STAT;
    assign hit_mask = REG_ADDR_IN == `BFAD_OFS_IRQ_MASK;

    always_ff @(posedge REF_CLK_IN) begin
        if (!RESET_N_IN) begin
            perf_event_select_three_ff <= `BFAD_RST_PERF_SEL3;
        end else if (REG_WR_IN && hit_sel) begin
            perf_event_select_three_ff <= REG_WDATA_IN[`BFAD_PERF_SEL_LSB +: 5];
        end
    end

    bfad_perf_counter u_perf (
        .clk_in(REF_CLK_IN),
        .rst_n_in(RESET_N_IN),
        .sel_in(perf_event_select_three_ff),
        .access_in(PERF_ACCESS_IN),
        .contested_in(PERF_CONTESTED_IN),
        .clear_in(REG_WR_IN && hit_ctr),
        .count_out(perf_counter_three),
        .sat_out(perf_sat)
    );

    bfad_irq_if irq_bus ();

    assign irq_bus.evt = {perf_sat, M1_VALID_IN && (g_core[1].nxt_route.target == bfad_pkg::TGT_NONE),
                          M0_VALID_IN && (g_core[0].nxt_route.target == bfad_pkg::TGT_NONE)};
    assign irq_bus.wr_stat = REG_WR_IN && hit_stat;
    assign irq_bus.wr_mask = REG_WR_IN && hit_mask;
    assign irq_bus.wdata = REG_WDATA_IN[2:0];

    bfad_irq_ctrl u_irq (
        .clk_in(REF_CLK_IN),
        .rst_n_in(RESET_N_IN),
        .bus(irq_bus)
    );

    assign IRQ_OUT = irq_bus.irq;

    // Read data stands only in the cycle after the strobe
    always_comb begin
        nxt_rdata = 32'h00000000;
        if (REG_RD_IN) begin
            if (hit_ctr) begin
                nxt_rdata = {8'h00, perf_counter_three};
            end else if (hit_sel) begin
                nxt_rdata = {27'h0000000, perf_event_select_three_ff};
            end else if (hit_stat) begin
                nxt_rdata = {29'h00000000, irq_bus.stat};
            end else if (hit_mask) begin
                nxt_rdata = {29'h00000000, irq_bus.mask};
            end
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (!RESET_N_IN) begin
            rdata_ff <= 32'h00000000;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign REG_RDATA_OUT = rdata_ff;

endmodule

`default_nettype wire

// ---- testbench/bfad_top_props.sv ----
`timescale 1ns/1ns
`default_nettype none

module bfad_top_props (
    input wire logic REF_CLK_IN, // Clock
    input wire logic RESET_N_IN, // Reset
    input wire logic [31:0] M0_ADDR_IN, // Core 0 address
    input wire logic M0_VALID_IN, // Core 0 request
    input wire logic [31:0] M1_ADDR_IN, // Core 1 address
    input wire logic M1_VALID_IN, // Core 1 request
    input wire logic [4:0] M0_TARGET_OUT, // Core 0 target
    input wire logic [4:0] M0_SLOT_OUT, // Core 0 slot
    input wire logic M0_SEL_OUT, // Core 0 hit
    input wire logic M0_ERROR_OUT, // Core 0 error
    input wire logic M1_ERROR_OUT, // Core 1 error
    input wire logic [25:0] IRQ_LINES_IN, // Interrupt lines
    input wire logic [25:0] CORE0_IRQ_OUT, // Lines to core 0
    input wire logic [25:0] CORE1_IRQ_OUT, // Lines to core 1
    input wire logic [7:0] REG_ADDR_IN, // Register address
    input wire logic REG_RD_IN, // Read strobe
    input wire logic [31:0] REG_RDATA_OUT // Read data
);
    // ------------------------------
    // Decode, interrupt fan-out and register checks
    // ------------------------------
    logic [31:0] m0_addr_ff;

    always_ff @(posedge REF_CLK_IN) begin
        m0_addr_ff <= M0_ADDR_IN;
    end

    default clocking cb @(posedge REF_CLK_IN);
    endclocking
    default disable iff (!RESET_N_IN);

    sequence s_m0_req(lo, hi);
        M0_VALID_IN && M0_ADDR_IN >= lo && M0_ADDR_IN < hi;
    endsequence

    AST_M0_ONE_HIT: assert property (M0_VALID_IN |=> M0_SEL_OUT != M0_ERROR_OUT)
        else $error("core 0 access gave no single outcome");
    AST_M0_IDLE: assert property (!M0_VALID_IN |=> !M0_SEL_OUT && !M0_ERROR_OUT
        && M0_TARGET_OUT == bfad_pkg::TGT_NONE) else $error("core 0 answer without request");
    AST_STRIPED: assert property (s_m0_req(32'h2000_0000, 32'h2004_0000)
        |=> M0_TARGET_OUT == bfad_pkg::TGT_SRAM_STRIPED) else $error("striped bank miss");
    AST_SRAM5: assert property (s_m0_req(32'h2004_1000, 32'h2004_2000)
        |=> M0_TARGET_OUT == bfad_pkg::TGT_SRAM5) else $error("bank five miss");
    AST_ALIAS: assert property (s_m0_req(32'h2100_0000, 32'h2104_0000)
        |=> M0_TARGET_OUT == bfad_pkg::TGT_SRAM_ALIAS && M0_SLOT_OUT == {3'h0, m0_addr_ff[17:16]})
        else $error("alias bank wrong");
    AST_APB_SLOT: assert property (s_m0_req(32'h4000_0000, 32'h4007_0000)
        |=> M0_TARGET_OUT == bfad_pkg::TGT_APB && M0_SLOT_OUT == m0_addr_ff[18:14])
        else $error("peripheral slot wrong");
    AST_M1_HOLE: assert property (M1_VALID_IN && M1_ADDR_IN[31:28] == 4'h3 |=> M1_ERROR_OUT)
        else $error("core 1 hole access not refused");
    AST_IRQ_FANOUT: assert property ($past(RESET_N_IN) |->
        CORE0_IRQ_OUT == $past(IRQ_LINES_IN) && CORE1_IRQ_OUT == CORE0_IRQ_OUT)
        else $error("interrupt lines not copied to both cores");
    AST_SEL_UPPER: assert property (REG_RD_IN && REG_ADDR_IN == 8'h24
        |=> REG_RDATA_OUT[31:5] == 27'h0) else $error("reserved select bits not zero");
endmodule

bind bfad_top bfad_top_props chk_u (.REF_CLK_IN, .RESET_N_IN, .M0_ADDR_IN, .M0_VALID_IN,
    .M1_ADDR_IN, .M1_VALID_IN, .M0_TARGET_OUT, .M0_SLOT_OUT, .M0_SEL_OUT, .M0_ERROR_OUT,
    .M1_ERROR_OUT, .IRQ_LINES_IN, .CORE0_IRQ_OUT, .CORE1_IRQ_OUT, .REG_ADDR_IN, .REG_RD_IN,
    .REG_RDATA_OUT);

`default_nettype wire

// ---- testbench/bfad_core_model.sv ----
`timescale 1ns/1ns
`default_nettype none

module bfad_core_model (
    input wire logic clk_in, // Clock
    input wire logic rst_n_in, // Reset, active low
    input wire logic go_in, // Issue one access
    input wire logic [31:0] addr_in, // Address to issue
    output logic [31:0] addr_out, // Bus address
    output logic valid_out // Bus request
);
    // Own port per core; a released address flips to its inverse every cycle
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            valid_out <= 1'b0;
            addr_out <= 32'h0;
        end else begin
            valid_out <= go_in;
            addr_out <= go_in ? addr_in : ~addr_out;
        end
    end
endmodule

`default_nettype wire

// ---- testbench/tb_bfad_top.sv ----
`timescale 1ns/1ns
`default_nettype none

module tb_bfad_top;
    localparam int N = 28;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] go = 2'h0;
    logic [31:0] cmd0 = 32'h0, cmd1 = 32'h0, a0, a1, wd = 32'h0, rdat;
    logic v0, v1, h0, h1, e0, e1, n0, n1, irq;
    logic [4:0] t0, t1, s0, s1;
    logic [9:0] acc = 10'h0, con = 10'h0;
    logic [25:0] lines = 26'h0, q0, q1;
    logic nmi = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [7:0] ra = 8'h0;
    int err_total = 0, checks = 0;
    logic [41:0] map [N] = '{
        {32'h0000_3FFC, bfad_pkg::TGT_ROM, 5'h0}, {32'h0000_4000, bfad_pkg::TGT_NONE, 5'h0},
        {32'h1000_0000, bfad_pkg::TGT_XIP_CACHE, 5'h0},
        {32'h1100_0000, bfad_pkg::TGT_XIP_NOALLOC, 5'h0},
        {32'h12FF_FFFC, bfad_pkg::TGT_XIP_NOCACHE, 5'h0},
        {32'h1300_0000, bfad_pkg::TGT_XIP_NCNA, 5'h0},
        {32'h1400_0000, bfad_pkg::TGT_XIP_CTRL, 5'h0},
        {32'h1500_3FFC, bfad_pkg::TGT_XIP_SRAM, 5'h0}, {32'h1500_4000, bfad_pkg::TGT_NONE, 5'h0},
        {32'h1800_0000, bfad_pkg::TGT_XIP_SSI, 5'h0},
        {32'h2000_0000, bfad_pkg::TGT_SRAM_STRIPED, 5'h0},
        {32'h2004_0000, bfad_pkg::TGT_SRAM4, 5'h0}, {32'h2004_1000, bfad_pkg::TGT_SRAM5, 5'h0},
        {32'h2004_2000, bfad_pkg::TGT_NONE, 5'h0},
        {32'h2103_0000, bfad_pkg::TGT_SRAM_ALIAS, 5'h3}, {32'h2104_0000, bfad_pkg::TGT_NONE, 5'h0},
        {32'h4000_4000, bfad_pkg::TGT_APB, 5'h1}, {32'h4006_C000, bfad_pkg::TGT_APB, 5'h1B},
        {32'h4007_0000, bfad_pkg::TGT_NONE, 5'h0}, {32'h5000_0000, bfad_pkg::TGT_DMA, 5'h0},
        {32'h5010_0000, bfad_pkg::TGT_USB_BUF, 5'h0}, {32'h5011_0000, bfad_pkg::TGT_USB_REGS, 5'h0},
        {32'h5020_0000, bfad_pkg::TGT_PIO_FIRST, 5'h0},
        {32'h5030_0000, bfad_pkg::TGT_PIO_SECOND, 5'h0},
        {32'h5040_0000, bfad_pkg::TGT_XIP_AUX, 5'h0},
        {32'hD000_0000, bfad_pkg::TGT_AUX_PORT, 5'h0}, {32'hE000_0000, bfad_pkg::TGT_PPB, 5'h0},
        {32'h3000_0000, bfad_pkg::TGT_NONE, 5'h0}};

    always #5 clk = ~clk;

    bfad_core_model core0_u (.clk_in(clk), .rst_n_in(rst_n), .go_in(go[0]), .addr_in(cmd0),
        .addr_out(a0), .valid_out(v0));
    bfad_core_model core1_u (.clk_in(clk), .rst_n_in(rst_n), .go_in(go[1]), .addr_in(cmd1),
        .addr_out(a1), .valid_out(v1));

    bfad_top dut_u (.REF_CLK_IN(clk), .RESET_N_IN(rst_n), .M0_ADDR_IN(a0), .M0_VALID_IN(v0),
        .M1_ADDR_IN(a1), .M1_VALID_IN(v1), .M0_TARGET_OUT(t0), .M0_SLOT_OUT(s0),
        .M0_SEL_OUT(h0), .M0_ERROR_OUT(e0), .M1_TARGET_OUT(t1), .M1_SLOT_OUT(s1),
        .M1_SEL_OUT(h1), .M1_ERROR_OUT(e1), .PERF_ACCESS_IN(acc), .PERF_CONTESTED_IN(con),
        .IRQ_LINES_IN(lines), .NMI_IN(nmi), .CORE0_IRQ_OUT(q0), .CORE1_IRQ_OUT(q1),
        .CORE0_NMI_OUT(n0), .CORE1_NMI_OUT(n1), .REG_ADDR_IN(ra), .REG_WDATA_IN(wd),
        .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdat), .IRQ_OUT(irq));

    // ------------------------------
    // Shared tasks
    // ------------------------------
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        ra <= a;
        wd <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        rd <= 1'b1;
        ra <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdat;
    endtask

    // Issue one access per selected core and stop where the answer stands
    task automatic req(input logic [1:0] g, input logic [31:0] x0, input logic [31:0] x1);
        @(posedge clk);
        go <= g;
        cmd0 <= x0;
        cmd1 <= x1;
        @(posedge clk);
        go <= 2'h0;
        @(posedge clk);
        #1;
    endtask

    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ------------------------------
    // Scenarios
    // ------------------------------
    task automatic t_regs;
        logic [31:0] d;
        reg_rd(8'h24, d);
        chk("select reset", d, 32'h0000_001F);
        reg_rd(8'h20, d);
        chk("counter reset", d, 32'h0);
        reg_wr(8'h24, 32'hFFFF_FFE5);
        reg_rd(8'h24, d);
        chk("select write", d, 32'h0000_0005);
        reg_wr(8'h30, 32'hFFFF_FFFF);
        reg_rd(8'h30, d);
        chk("unmapped offset", d, 32'h0);
        @(posedge clk);
        lines <= 26'h2AA_AAAA;
        nmi <= 1'b1;
        @(posedge clk);
        #1;
        chk("core 0 lines", {5'h0, n0, q0}, {5'h0, 1'b1, 26'h2AA_AAAA});
        chk("core 1 lines", {5'h0, n1, q1}, {5'h0, 1'b1, 26'h2AA_AAAA});
    endtask

    task automatic t_decode;
        logic [41:0] p, q;
        for (int i = 0; i < N; i++) begin
            p = map[i];
            q = map[N - 1 - i];
            req(2'h3, p[41:10], q[41:10]);
            chk("m0 target", {27'h0, t0}, {27'h0, p[9:5]});
            chk("m0 slot", {27'h0, s0}, {27'h0, p[4:0]});
            chk("m0 flags", {30'h0, h0, e0}, {30'h0, p[9:5] != 5'h0, p[9:5] == 5'h0});
            chk("m1 target", {22'h0, t1, s1}, {22'h0, q[9:0]});
            chk("m1 flags", {30'h0, h1, e1}, {30'h0, q[9:5] != 5'h0, q[9:5] == 5'h0});
        end
    endtask

    task automatic t_irq;
        logic [31:0] d;
        reg_wr(8'h2C, 32'h3);
        reg_wr(8'h28, 32'h7);
        reg_rd(8'h28, d);
        chk("status cleared", {d[31:1], irq}, 32'h0);
        req(2'h1, 32'h3000_0000, 32'h2000_0000);
        @(posedge clk);
        #1 chk("core 0 error irq", {31'h0, irq}, 32'h1);
        reg_wr(8'h2C, 32'h2);
        @(posedge clk);
        #1 chk("masked irq", {31'h0, irq}, 32'h0);
        req(2'h2, 32'h2000_0000, 32'h6000_0000);
        reg_rd(8'h28, d);
        chk("error status", {d[31:1], irq}, 32'h3);
        reg_wr(8'h28, 32'h3);
        @(posedge clk);
        #1 chk("irq cleared", {31'h0, irq}, 32'h0);
    endtask

    task automatic t_perf;
        logic [31:0] d;
        logic [9:0] m;
        for (int c = 0; c < 21; c++) begin
            m = 10'h1 << (c >> 1);
            reg_wr(8'h24, 32'(c));
            reg_wr(8'h20, 32'h0);
            @(posedge clk);
            acc <= c[0] ? m : ~m;
            con <= c[0] ? ~m : m;
            repeat (3) @(posedge clk);
            acc <= 10'h0;
            con <= 10'h0;
            reg_rd(8'h20, d);
            chk("perf count", d, (c < 20) ? 32'h3 : 32'h0);
        end
    endtask

    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        t_regs;
        t_decode;
        t_irq;
        t_perf;
        finish_test;
    end

    initial begin
        #100000;
        err_total++;
        finish_test;
    end
endmodule

`default_nettype wire
